// ==== core/lrlbb_defines.svh ====
`ifndef LRLBB_DEFINES_SVH
`define LRLBB_DEFINES_SVH

// display RAM geometry
`define LRLBB_LAST_WORD    6'h27
// upper six bits of the two-wire slave address, low bit from strap
`define LRLBB_SLV_ADDR_HI  6'h1C
// multiplex mode codes of the mode-set command
`define LRLBB_MUX_STATIC   2'h1
`define LRLBB_MUX_12       2'h2
`define LRLBB_MUX_13       2'h3
`define LRLBB_MUX_14       2'h0
// frame divisors, clock cycles per four-row (1:4) frame; each row lasts a quarter in every mode
`define LRLBB_FRAME_NP     2880
`define LRLBB_FRAME_LP     480
`define LRLBB_ROW_CYC_NP   12'(`LRLBB_FRAME_NP / 4)
`define LRLBB_ROW_CYC_LP   12'(`LRLBB_FRAME_LP / 4)
// blink divisors, clock cycles per blink period
`define LRLBB_BLINK_NP1    92160
`define LRLBB_BLINK_NP2    184320
`define LRLBB_BLINK_NP3    368640
`define LRLBB_BLINK_LP1    15360
`define LRLBB_BLINK_LP2    30720
`define LRLBB_BLINK_LP3    61440

`endif

// ==== core/lrlbb_pkg.sv ====
package lrlbb_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_CMD,
      ST_DATA,
      ST_IGNORE
   } lrlbb_bus_st_t;
endpackage

// ==== core/lrlbb_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module lrlbb_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic [W-1:0] din,
   input  wire logic [W-1:0] rst_val,
   output logic      [W-1:0] dout
);
   logic [W-1:0] ff1_r;
   logic [W-1:0] ff2_r;
   logic [W-1:0] ff3_r;
   logic [W-1:0] out_r;
   logic [W-1:0] init_r;

   // reset values are constants; the idle level is taken once after release
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ff1_r  <= '0;
         ff2_r  <= '0;
         ff3_r  <= '0;
         // idle-high start avoids an edge in the first cycle after release; the zeroed stages still pull the output low for the two cycles after that
         out_r  <= '1;
         init_r <= '1;
      end else if (ce) begin
         ff1_r <= din;
         ff2_r <= ff1_r;
         ff3_r <= ff2_r;
         for (int i = 0; i < W; i++) begin
            if (init_r[i]) begin
               out_r[i] <= rst_val[i];
            end else if (ff2_r[i] == ff3_r[i]) begin
               out_r[i] <= ff3_r[i];
            end
         end
         if (ff2_r == ff3_r) begin
            init_r <= '0;
         end
      end
   end

   assign dout = out_r;
endmodule
`default_nettype wire

// ==== core/lrlbb_ram.sv ====
`timescale 1ns/100ps
`default_nettype none
module lrlbb_ram #(
   parameter int unsigned DEPTH = 40
) (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       ce,
   input  wire logic       we,
   input  wire logic [5:0] waddr,
   input  wire logic [3:0] wdata,
   input  wire logic [3:0] wmask,
   input  wire logic [5:0] raddr,
   output logic      [3:0] rdata
);
   logic [3:0] mem [DEPTH];
   logic [3:0] rdata_r;

   if (DEPTH > 64 || DEPTH < 1) begin : g_bad_depth
      $error("lrlbb_ram: depth out of range");
   end

   // masked write keeps untouched rows of a word intact
   always_ff @(posedge clk_sys) begin
      if (ce && we && (32'(waddr) < DEPTH)) begin
         mem[waddr] <= (mem[waddr] & ~wmask) | (wdata & wmask);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 4'h0;
      end else if (ce && (32'(raddr) < DEPTH)) begin
         rdata_r <= mem[raddr];
      end
   end

   assign rdata = rdata_r;
endmodule
`default_nettype wire

// ==== core/lrlbb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "lrlbb_defines.svh"
module lrlbb_top #(
   parameter int unsigned BLINK_NP1 = `LRLBB_BLINK_NP1,
   parameter int unsigned BLINK_NP2 = `LRLBB_BLINK_NP2,
   parameter int unsigned BLINK_NP3 = `LRLBB_BLINK_NP3,
   parameter int unsigned BLINK_LP1 = `LRLBB_BLINK_LP1,
   parameter int unsigned BLINK_LP2 = `LRLBB_BLINK_LP2,
   parameter int unsigned BLINK_LP3 = `LRLBB_BLINK_LP3
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   input  wire logic        strap_sub_id_bit0,
   input  wire logic        strap_sub_id_bit1,
   input  wire logic        strap_sub_id_bit2,
   input  wire logic        strap_slv_lsb,
   output logic             scl_o,
   output logic             scl_oe,
   output logic             sda_o,
   output logic             sda_oe,
   output logic      [39:0] disp_seg,
   output logic      [1:0]  disp_bp,
   output logic             disp_blank,
   output logic             disp_en,
   output logic             disp_lp,
   output logic             disp_bias,
   output logic      [1:0]  disp_mux
);
   for (genvar g = 0; g < 6; g++) begin : g_chk
      localparam int unsigned D = (g == 0) ? BLINK_NP1 : (g == 1) ? BLINK_NP2 : (g == 2) ? BLINK_NP3 :
                                  (g == 3) ? BLINK_LP1 : (g == 4) ? BLINK_LP2 : BLINK_LP3;
      if (D < 2 || D > 1048574 || (D % 2) != 0) begin : g_bad
         $error("lrlbb_top: blink divisor must be even and below 2^20");
      end
   end

   localparam logic [18:0] H_NP1 = 19'(BLINK_NP1 / 2);
   localparam logic [18:0] H_NP2 = 19'(BLINK_NP2 / 2);
   localparam logic [18:0] H_NP3 = 19'(BLINK_NP3 / 2);
   localparam logic [18:0] H_LP1 = 19'(BLINK_LP1 / 2);
   localparam logic [18:0] H_LP2 = 19'(BLINK_LP2 / 2);
   localparam logic [18:0] H_LP3 = 19'(BLINK_LP3 / 2);

   logic [5:0]                pin_s;
   logic                      scl_s;
   logic                      sda_s;
   logic [2:0]                strap_s;
   logic                      slv_lsb_s;
   logic                      scl_q_r;
   logic                      sda_q_r;
   lrlbb_pkg::lrlbb_bus_st_t  st_r;
   logic [3:0]                bit_cnt_r;
   logic [7:0]                rx_r;
   logic                      ack_pend_r;
   logic                      ack_end_r;
   logic                      sda_oe_r;
   logic                      scl_oe_r;
   logic                      scl_o_r;
   logic                      sda_o_r;
   logic                      lp_r;
   logic                      en_r;
   logic                      bias_r;
   logic [1:0]                mux_r;
   logic                      in_bank_r;
   logic                      out_bank_r;
   logic                      ab_r;
   logic [1:0]                bf_r;
   logic                      busy_r;
   logic [3:0]                words_r;
   logic [7:0]                sh_r;
   logic [5:0]                ptr_r;
   logic [2:0]                sub_r;
   logic [18:0]               blk_cnt_r;
   logic                      blk_ph_r;
   logic [11:0]               row_tmr_r;
   logic [1:0]                bp_r;
   logic [1:0]                scan_bp_r;
   logic [1:0]                scan_row_r;
   logic                      scan_r;
   logic                      last_r;
   logic                      rd_v_r;
   logic [5:0]                col_r;
   logic [39:0]               seg_sh_r;
   logic [39:0]               disp_seg_r;
   logic [1:0]                disp_bp_r;
   logic                      disp_blank_r;
   logic [3:0]                rd_data;
   logic                      start_c;
   logic                      stop_c;
   logic                      rise_c;
   logic                      fall_c;
   logic [7:0]                byte_w;
   logic                      byte_c;
   logic                      cmd_c;
   logic                      data_c;
   logic                      sub_match;
   logic                      ram_we;
   logic [3:0]                wdata;
   logic [3:0]                wmask;
   logic [3:0]                nwords;
   logic [2:0]                step;
   logic [1:0]                last_bp;
   logic [18:0]               blk_half;
   logic [11:0]               row_cyc;
   logic                      bank_mode;
   logic                      out_bank_eff;

   // idle level of both bus lines is high, so the sync starts there
   lrlbb_sync #(.W(6)) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .ce      (ce),
      .din     ({scl_i, sda_i, strap_sub_id_bit2, strap_sub_id_bit1, strap_sub_id_bit0, strap_slv_lsb}),
      .rst_val ({2'h3, strap_sub_id_bit2, strap_sub_id_bit1, strap_sub_id_bit0, strap_slv_lsb}),
      .dout    (pin_s)
   );
   assign scl_s     = pin_s[5];
   assign sda_s     = pin_s[4];
   assign strap_s   = pin_s[3:1];
   assign slv_lsb_s = pin_s[0];

   lrlbb_ram #(.DEPTH(40)) u_ram (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .ce      (ce),
      .we      (ram_we),
      .waddr   (ptr_r),
      .wdata   (wdata),
      .wmask   (wmask),
      .raddr   (col_r),
      .rdata   (rd_data)
   );

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end else if (ce) begin
         scl_q_r <= scl_s;
         sda_q_r <= sda_s;
      end
   end

   assign start_c = ce & scl_s & scl_q_r & sda_q_r & ~sda_s;
   assign stop_c  = ce & scl_s & scl_q_r & ~sda_q_r & sda_s;
   assign rise_c  = ce & scl_s & ~scl_q_r;
   assign fall_c  = ce & ~scl_s & scl_q_r;
   assign byte_w  = {rx_r[6:0], sda_s};
   assign byte_c  = rise_c & (bit_cnt_r == 4'h7);
   assign cmd_c   = byte_c & (st_r == lrlbb_pkg::ST_CMD);
   assign data_c  = byte_c & (st_r == lrlbb_pkg::ST_DATA);
   assign sub_match = (sub_r == strap_s);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_r       <= lrlbb_pkg::ST_IDLE;
         bit_cnt_r  <= 4'h0;
         rx_r       <= 8'h00;
         ack_pend_r <= 1'b0;
         ack_end_r  <= 1'b0;
         sda_oe_r   <= 1'b0;
      end else if (start_c) begin
         st_r       <= lrlbb_pkg::ST_ADDR;
         bit_cnt_r  <= 4'h0;
         ack_pend_r <= 1'b0;
         ack_end_r  <= 1'b0;
         sda_oe_r   <= 1'b0;
      end else if (stop_c) begin
         st_r     <= lrlbb_pkg::ST_IDLE;
         sda_oe_r <= 1'b0;
      end else if (st_r != lrlbb_pkg::ST_IDLE && rise_c) begin
         if (bit_cnt_r == 4'h8) begin
            bit_cnt_r <= 4'h0;
            ack_end_r <= 1'b1;
         end else begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            rx_r      <= byte_w;
         end
         if (byte_c) begin
            case (st_r)
               lrlbb_pkg::ST_ADDR: begin
                  // write-only slave: a read request is ignored to the stop
                  if (byte_w[7:1] == {`LRLBB_SLV_ADDR_HI, slv_lsb_s} && !byte_w[0]) begin
                     st_r       <= lrlbb_pkg::ST_CMD;
                     ack_pend_r <= 1'b1;
                  end else begin
                     st_r       <= lrlbb_pkg::ST_IGNORE;
                     ack_pend_r <= 1'b0;
                  end
               end
               lrlbb_pkg::ST_CMD: begin
                  ack_pend_r <= 1'b1;
                  if (!byte_w[7]) begin
                     st_r <= lrlbb_pkg::ST_DATA;
                  end
               end
               lrlbb_pkg::ST_DATA: ack_pend_r <= sub_match;
               default:            ack_pend_r <= 1'b0;
            endcase
         end
      end else if (st_r != lrlbb_pkg::ST_IDLE && fall_c) begin
         if (bit_cnt_r == 4'h8 && ack_pend_r) begin
            sda_oe_r <= 1'b1;
         end
         if (ack_end_r) begin
            sda_oe_r   <= 1'b0;
            ack_end_r  <= 1'b0;
            ack_pend_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lp_r       <= 1'b0;
         en_r       <= 1'b0;
         bias_r     <= 1'b0;
         mux_r      <= `LRLBB_MUX_14;
         in_bank_r  <= 1'b0;
         out_bank_r <= 1'b0;
         ab_r       <= 1'b0;
         bf_r       <= 2'h0;
      end else if (cmd_c) begin
         if (byte_w[6:5] == 2'h2) begin
            lp_r   <= byte_w[4];
            en_r   <= byte_w[3];
            bias_r <= byte_w[2];
            mux_r  <= byte_w[1:0];
         end else if (byte_w[6:2] == 5'h1E) begin
            in_bank_r  <= byte_w[1];
            out_bank_r <= byte_w[0];
         end else if (byte_w[6:3] == 4'hE) begin
            ab_r <= byte_w[2];
            bf_r <= byte_w[1:0];
         end
      end
   end

   // words per byte, bits per word, last row
   always_comb begin
      case (mux_r)
         `LRLBB_MUX_STATIC: begin
            nwords  = 4'h8;
            step    = 3'h1;
            last_bp = 2'h0;
         end
         `LRLBB_MUX_12: begin
            nwords  = 4'h4;
            step    = 3'h2;
            last_bp = 2'h1;
         end
         // triples: shift by three, third word keeps two bits
         `LRLBB_MUX_13: begin
            nwords  = 4'h3;
            step    = 3'h3;
            last_bp = 2'h2;
         end
         default: begin
            nwords  = 4'h2;
            step    = 3'h4;
            last_bp = 2'h3;
         end
      endcase
   end

   // gate only the write, never the pointer
   assign ram_we = busy_r & sub_match;

   always_comb begin
      case (mux_r)
         `LRLBB_MUX_STATIC: begin
            wdata = {4{sh_r[7]}};
            wmask = in_bank_r ? 4'h4 : 4'h1;
         end
         `LRLBB_MUX_12: begin
            wdata = {sh_r[6], sh_r[7], sh_r[6], sh_r[7]};
            wmask = in_bank_r ? 4'hC : 4'h3;
         end
         // last word holds two bits only
         `LRLBB_MUX_13: begin
            wdata = {1'b0, sh_r[5], sh_r[6], sh_r[7]};
            wmask = (words_r == 4'h1) ? 4'h3 : 4'h7;
         end
         default: begin
            wdata = {sh_r[4], sh_r[5], sh_r[6], sh_r[7]};
            wmask = 4'hF;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         busy_r  <= 1'b0;
         words_r <= 4'h0;
         sh_r    <= 8'h00;
         ptr_r   <= 6'h00;
         sub_r   <= 3'h0;
      end else if (ce) begin
         // start storing on the eighth bit, ack not awaited
         if (data_c) begin
            busy_r  <= 1'b1;
            sh_r    <= byte_w;
            words_r <= nwords;
         end else if (busy_r) begin
            sh_r    <= sh_r << step;
            words_r <= words_r - 4'h1;
            busy_r  <= (words_r != 4'h1);
            if (ptr_r == `LRLBB_LAST_WORD) begin
               ptr_r <= 6'h00;
               sub_r <= sub_r + 3'h1;
            end else begin
               ptr_r <= ptr_r + 6'h01;
            end
         end
         if (cmd_c && !byte_w[6]) begin
            // pointer load, out-of-range value parks at word 0
            ptr_r <= (byte_w[5:0] > `LRLBB_LAST_WORD) ? 6'h00 : byte_w[5:0];
         end
         if (cmd_c && byte_w[6:3] == 4'hC) begin
            sub_r <= byte_w[2:0];
         end
      end
   end

   // stretch the low phase until the byte is stored
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         scl_oe_r <= 1'b0;
         scl_o_r  <= 1'b0;
         sda_o_r  <= 1'b0;
      end else if (ce) begin
         if (fall_c && busy_r) begin
            scl_oe_r <= 1'b1;
         end else if (!busy_r) begin
            scl_oe_r <= 1'b0;
         end
      end
   end

   always_comb begin
      case ({lp_r, bf_r})
         3'h1:    blk_half = H_NP1;
         3'h2:    blk_half = H_NP2;
         3'h3:    blk_half = H_NP3;
         3'h5:    blk_half = H_LP1;
         3'h6:    blk_half = H_LP2;
         3'h7:    blk_half = H_LP3;
         default: blk_half = 19'h00001;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         blk_cnt_r <= 19'h00000;
         blk_ph_r  <= 1'b0;
      end else if (ce) begin
         if (bf_r == 2'h0) begin
            blk_cnt_r <= 19'h00000;
            blk_ph_r  <= 1'b0;
         end else if (blk_cnt_r >= blk_half - 19'h00001) begin
            blk_cnt_r <= 19'h00000;
            blk_ph_r  <= ~blk_ph_r;
         end else begin
            blk_cnt_r <= blk_cnt_r + 19'h00001;
         end
      end
   end

   // alternate output bank, swapped at the blink phase
   assign bank_mode    = (mux_r == `LRLBB_MUX_STATIC) || (mux_r == `LRLBB_MUX_12);
   assign out_bank_eff = bank_mode & (out_bank_r ^ (ab_r & blk_ph_r));
   assign row_cyc      = lp_r ? `LRLBB_ROW_CYC_LP : `LRLBB_ROW_CYC_NP;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         row_tmr_r  <= 12'h000;
         bp_r       <= 2'h0;
         scan_bp_r  <= 2'h0;
         scan_row_r <= 2'h0;
         scan_r     <= 1'b0;
         last_r     <= 1'b0;
         rd_v_r     <= 1'b0;
         col_r      <= 6'h00;
         seg_sh_r   <= 40'h00_0000_0000;
         disp_seg_r <= 40'h00_0000_0000;
         disp_bp_r  <= 2'h0;
      end else if (ce) begin
         rd_v_r <= scan_r;
         last_r <= scan_r && (col_r == `LRLBB_LAST_WORD);
         if (row_tmr_r >= row_cyc - 12'h001) begin
            row_tmr_r  <= 12'h000;
            bp_r       <= (bp_r >= last_bp) ? 2'h0 : bp_r + 2'h1;
            scan_bp_r  <= bp_r;
            scan_row_r <= bp_r | {out_bank_eff, 1'b0};
            scan_r     <= 1'b1;
            col_r      <= 6'h00;
         end else begin
            row_tmr_r <= row_tmr_r + 12'h001;
            if (scan_r) begin
               col_r  <= (col_r == `LRLBB_LAST_WORD) ? 6'h00 : col_r + 6'h01;
               scan_r <= (col_r != `LRLBB_LAST_WORD);
            end
         end
         // element state follows the stored bit directly
         if (rd_v_r) begin
            seg_sh_r <= {rd_data[scan_row_r], seg_sh_r[39:1]};
         end
         if (last_r) begin
            disp_seg_r <= {rd_data[scan_row_r], seg_sh_r[39:1]};
            disp_bp_r  <= scan_bp_r;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         disp_blank_r <= 1'b1;
      end else if (ce) begin
         disp_blank_r <= ~en_r | ((bf_r != 2'h0) & ~(ab_r & bank_mode) & blk_ph_r);
      end
   end

   assign scl_o      = scl_o_r;
   assign scl_oe     = scl_oe_r;
   assign sda_o      = sda_o_r;
   assign sda_oe     = sda_oe_r;
   assign disp_seg   = disp_seg_r;
   assign disp_bp    = disp_bp_r;
   assign disp_blank = disp_blank_r;
   assign disp_en    = en_r;
   assign disp_lp    = lp_r;
   assign disp_bias  = bias_r;
   assign disp_mux   = mux_r;

   chk_ptr_range: assert property (@(posedge clk_sys) disable iff (!rst_n) ptr_r <= `LRLBB_LAST_WORD)
      else $error("pointer beyond last word");
   chk_wrap_sub: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ce && busy_r && !data_c && !cmd_c && ptr_r == `LRLBB_LAST_WORD) |=> (ptr_r == 6'h00 && sub_r == 3'($past(sub_r) + 3'h1)))
      else $error("overflow did not bump subaddress");
   chk_write_gate: assert property (@(posedge clk_sys) disable iff (!rst_n) ram_we |-> (sub_r == strap_s))
      else $error("write with foreign subaddress");
   chk_skip_adv: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ce && busy_r && !sub_match && !cmd_c && ptr_r != `LRLBB_LAST_WORD) |=> (ptr_r == 6'($past(ptr_r) + 6'h01)))
      else $error("pointer stalled on blocked write");
   chk_words_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (data_c && mux_r == `LRLBB_MUX_13) |=> (busy_r && words_r == 4'h3) ##1 (!ce || words_r == 4'h2))
      else $error("wrong word count for 1:3");
   chk_mask_13: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ram_we && mux_r == `LRLBB_MUX_13) |-> (wmask[3] == 1'b0 && (words_r != 4'h1 || wmask == 4'h3)))
      else $error("1:3 mask touches row 3");
   chk_bank_in: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ram_we && mux_r == `LRLBB_MUX_STATIC && in_bank_r) |-> (wmask == 4'h4))
      else $error("static alternate bank not row 2");
   chk_scl_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fall_c && busy_r) |=> scl_oe_r ##1 (scl_oe_r || !busy_r))
      else $error("SCL not held while busy");
   chk_start_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
      start_c |=> (st_r == lrlbb_pkg::ST_ADDR && bit_cnt_r == 4'h0 && !sda_oe_r))
      else $error("START not taken");
   chk_blink_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ce && bf_r == 2'h0) |=> (!blk_ph_r && blk_cnt_r == 19'h00000))
      else $error("blink runs while off");
   chk_blank_en: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ce && en_r && ab_r && bank_mode) |=> !disp_blank_r)
      else $error("bank blink blanked display");
endmodule
`default_nettype wire

// ==== sim/lrlbb_bus_master.sv ====
`timescale 1ns/100ps
`default_nettype none
module lrlbb_bus_master (
   input  wire logic clk_sys,
   input  wire logic scl_oe,
   input  wire logic sda_oe,
   output logic      scl_i,
   output logic      sda_i
);
   logic scl_lo = 1'b0;
   logic sda_lo = 1'b0;
   assign scl_i = ~(scl_lo | scl_oe);
   assign sda_i = ~(sda_lo | sda_oe);
   task automatic hold(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic rise;
      int k;
      scl_lo <= 1'b0;
      hold(2);
      for (k = 0; k < 200 && !scl_i; k++) hold(1);
      hold(10);
   endtask
   task automatic start;
      sda_lo <= 1'b1;
      hold(10);
      scl_lo <= 1'b1;
      hold(10);
   endtask
   // sda moves only while scl low
   task automatic wbyte(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_lo <= ~d[i];
         hold(10);
         rise();
         scl_lo <= 1'b1;
         hold(2);
      end
      sda_lo <= 1'b0;
      hold(10);
      rise();
      ack = ~sda_i;
      scl_lo <= 1'b1;
      hold(10);
   endtask
   task automatic stop;
      sda_lo <= 1'b1;
      hold(10);
      rise();
      sda_lo <= 1'b0;
      hold(10);
   endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "lrlbb_defines.svh"
module tb;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        scl_i, sda_i, scl_oe, sda_oe;
   logic [39:0] disp_seg;
   logic [1:0]  disp_bp;
   logic        scl_o, sda_o, disp_blank, disp_en, disp_lp, disp_bias;
   logic [1:0]  disp_mux;
   int          err_count = 0;
   int          checks = 0;
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
   always #12.5 clk_sys = ~clk_sys;
   lrlbb_bus_master m (.clk_sys(clk_sys), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl_i(scl_i), .sda_i(sda_i));
   lrlbb_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .scl_i(scl_i), .sda_i(sda_i),
      .strap_sub_id_bit0(1'b0), .strap_sub_id_bit1(1'b0), .strap_sub_id_bit2(1'b0),
      .strap_slv_lsb(1'b0), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe),
      .disp_seg(disp_seg), .disp_bp(disp_bp), .disp_blank(disp_blank), .disp_en(disp_en),
      .disp_lp(disp_lp), .disp_bias(disp_bias), .disp_mux(disp_mux));
   task automatic give_verdict;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // first na bytes must be acknowledged
   task automatic txn(input logic [7:0] q[$], input int na);
      logic ack;
      m.start();
      foreach (q[i]) begin
         m.wbyte(q[i], ack);
         if (i < na) `CHK("ack", 1'b1, ack)
      end
      m.stop();
   endtask
   // a full frame first, so the shown row postdates the write
   task automatic row_wait(input logic [1:0] bp);
      int k;
      repeat (3000) @(posedge clk_sys);
      for (k = 0; k < 4000 && disp_bp !== bp; k++) @(negedge clk_sys);
      if (k == 4000) begin
         err_count++;
         give_verdict();
      end
      @(negedge clk_sys);
   endtask
   task automatic t_static;
      txn({8'h70, 8'hC9, 8'h00, 8'hC0}, 3);
      row_wait(2'h0);
      `CHK("static row0", 40'h03, disp_seg & 40'hFF)
   endtask
   // two bytes in 1:4: pointer steps by two words
   task automatic t_quad;
      txn({8'h70, 8'hC8, 8'h00, 8'hA5, 8'h3C}, 3);
      row_wait(2'h0);
      `CHK("quad row0", 40'h9, disp_seg & 40'hF)
      row_wait(2'h1);
      `CHK("quad row1", 40'hA, disp_seg & 40'hF)
   endtask
   // byte straddles word 39: second half goes to next device
   task automatic t_cascade;
      txn({8'h70, 8'hC8, 8'hE0, 8'h27, 8'hF0}, 4);
      row_wait(2'h0);
      `CHK("wrap row0", 40'h8000000001, disp_seg & 40'h8000000001)
   endtask
   // first transfer reloads the pointer, subaddress back to 0; second only switches the output bank back to bank 0, the input bank stays at 1
   task automatic t_bank;
      txn({8'h70, 8'hCA, 8'hE0, 8'hFB, 8'h00, 8'h81}, 5);
      `CHK("mux 1:2", 2'h2, disp_mux)
      row_wait(2'h0);
      `CHK("alt row2", 40'h1, disp_seg & 40'hF)
      row_wait(2'h1);
      `CHK("alt row3", 40'h8, disp_seg & 40'hF)
      txn({8'h70, 8'h7A}, 2);
      row_wait(2'h0);
      `CHK("main row0", 40'h9, disp_seg & 40'hF)
   endtask
   task automatic t_triple;
      txn({8'h70, 8'hCB, 8'h05, 8'hFF}, 3);
      row_wait(2'h0);
      `CHK("triple row0", 40'h7, (disp_seg >> 5) & 40'h7)
      row_wait(2'h2);
      `CHK("triple row2", 40'h3, (disp_seg >> 5) & 40'h3)
      `CHK("mux 1:3", 2'h3, disp_mux)
   endtask
   task automatic t_blink;
      int n;
      txn({8'h70, 8'hDC, 8'h71}, 3);
      `CHK("lp bias", 2'h3, {disp_lp, disp_bias})
      for (n = 0; n < 20000 && disp_blank !== 1'b0; n++) @(negedge clk_sys);
      for (n = 0; n < 20000 && disp_blank !== 1'b1; n++) @(negedge clk_sys);
      for (n = 0; n < 20000 && disp_blank === 1'b1; n++) @(negedge clk_sys);
      `CHK("blink half", `LRLBB_BLINK_LP1 / 2, n)
      txn({8'h70, 8'hC0, 8'h70}, 3);
      `CHK("blank en off", 2'h2, {disp_blank, disp_en})
      txn({8'h70, 8'h48}, 2);
      `CHK("blank en on", 2'h1, {disp_blank, disp_en})
      `CHK("pull levels", 2'h0, {scl_o, sda_o})
   endtask
   initial begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (10) @(posedge clk_sys);
      t_static();
      t_quad();
      t_cascade();
      t_bank();
      t_triple();
      t_blink();
      give_verdict();
   end
endmodule
`default_nettype wire
